// File: rtl/icap_pkg.sv
// Package: constants and types for the IDE combo arbiter and power control
package icap_pkg;
   // Strap values that enable sharing
   localparam logic       POWER_SELF_LEVEL  = 1'b0;
   localparam logic       CLOCK_COMBO_LEVEL = 1'b1;
   // Clock rates per mode, in kHz
   localparam int         CLK_BUS_KHZ       = 7500;
   localparam int         CLK_SELF_KHZ      = 60000;
   // Clock of this logic, in MHz
   localparam int         SYS_CLK_MHZ       = 50;
   // Back-off after a tie, in ns, and derived cycles
   localparam int         BACKOFF_NS        = 400;
   localparam int         BACKOFF_CYC       = (BACKOFF_NS * SYS_CLK_MHZ + 999)
                                              / 1000;
   // Settle wait after claim before driving, in cycles
   localparam int         SETTLE_CYC        = 2;
   // Level on the power control pin that removes target power
   localparam logic       TPWR_OFF_LEVEL    = 1'b1;
   // Reset values
   localparam logic       CLAIM_RST         = 1'b0;
   localparam logic [7:0] COUNT_RST         = 8'h00;

   typedef enum logic [1:0] {
      ICAP_IDLE  = 2'b00,
      ICAP_CLAIM = 2'b01,
      ICAP_OWN   = 2'b11,
      ICAP_BACK  = 2'b10
   } icap_arb_e;

   typedef enum logic [1:0] {
      ICAP_USB_DEFAULT    = 2'b00,
      ICAP_USB_ADDRESSED  = 2'b01,
      ICAP_USB_CONFIGURED = 2'b10,
      ICAP_USB_SUSPENDED  = 2'b11
   } icap_usb_e;
endpackage

// File: rtl/icap_arbiter.sv
// Combo bus arbiter and target power control for one shared IDE target
`timescale 1ns/1ps
// What this block does
// - Combo sharing only when power strap is 0 and clock strap 1.
// - Our claim output is high while requesting or using the bus.
// - Sample peer claim first; start driving only if peer stayed idle through our claim.
// - Two system clock modes: 7.5 MHz bus-powered with clock strap 1, else 60 MHz.
// - Power control pin released from reset until initialization is done.
// - Target power cut in default or unconfigured USB state.
// - Target power also cut in USB suspend.
// - Power control level follows the USB state only.
module icap_arbiter
#(
   parameter int BACKOFF = icap_pkg::BACKOFF_CYC
)
(
   input  wire logic              clk,
   input  wire logic              reset_n,
   input  wire logic              power_source_strap,
   input  wire logic              clock_rate_strap,
   input  wire logic              target_type_strap_hi,
   input  wire logic              target_type_strap_lo,
   input  wire logic              peer_claim_in,
   input  wire logic              ide_request,
   input  wire logic              ide_done,
   output logic                   ide_grant,
   output logic                   ide_drive_en,
   output logic                   bus_claim_out,
   output logic                   bus_claim_oe,
   output logic                   combo_mode,
   output logic                   fast_clock_sel,
   input  wire logic              init_done,
   input  wire icap_pkg::icap_usb_e usb_state,
   output logic                   target_power_ctrl,
   output logic                   target_power_oe
);
   import icap_pkg::*;

   default clocking cb_sys @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   // ===================================================
   // Parameter check
   // The back-off counter is eight bits wide and must run at least once
   if (BACKOFF < 1 || BACKOFF > 255)
   begin : g_bad_backoff
      $error("BACKOFF must lie in 1..255");
   end

   // ===================================================
   // State
   typedef struct packed {
      logic [2:0] peer_sync;
      logic [2:0] src_sync;
      logic [2:0] rate_sync;
      logic       peer;
      icap_arb_e  arb;
      logic [7:0] count;
      logic       combo;
      logic       fast;
      logic       inited;
      logic       tpwr;
   } icap_state_s;

   icap_state_s st;
   icap_state_s next_st;
   logic        combo_raw;
   logic        fast_raw;
   logic        straps_agree;

   // Straps are pins, so they pass the same three stages as the peer claim
   assign combo_raw    = (st.src_sync[2] == POWER_SELF_LEVEL)
                      && (st.rate_sync[2] == CLOCK_COMBO_LEVEL);
   // Self-powered straps select the fast clock
   assign fast_raw     = (st.src_sync[2] == POWER_SELF_LEVEL)
                      || !st.rate_sync[2];
   assign straps_agree = (st.src_sync[1] == st.src_sync[2])
                      && (st.rate_sync[1] == st.rate_sync[2]);

   // ===================================================
   // Next state
   always_comb
   begin
      next_st = st;
      next_st.peer_sync = {st.peer_sync[1:0], peer_claim_in};
      // Second and third stage agree before the peer level counts
      if (st.peer_sync[1] == st.peer_sync[2])
         next_st.peer = st.peer_sync[2];
      next_st.src_sync  = {st.src_sync[1:0], power_source_strap};
      next_st.rate_sync = {st.rate_sync[1:0], clock_rate_strap};
      // Mode bits move only once a strap change has settled
      if (straps_agree)
      begin
         next_st.combo = combo_raw;
         next_st.fast  = fast_raw;
      end
      next_st.inited = st.inited | init_done;
      next_st.tpwr   = (usb_state == ICAP_USB_CONFIGURED)
                     ? ~TPWR_OFF_LEVEL : TPWR_OFF_LEVEL;
      case (st.arb)
         ICAP_IDLE:
         begin
            next_st.count = COUNT_RST;
            if (ide_request)
            begin
               if (!st.combo)
                  next_st.arb = ICAP_OWN;
               else if (!st.peer)
                  next_st.arb = ICAP_CLAIM;
            end
         end
         ICAP_CLAIM:
         begin
            // Wait long enough to see a peer claim raised alongside ours
            if (!ide_request)
               next_st.arb = ICAP_IDLE;
            else if (st.peer)
            begin
               next_st.arb   = ICAP_BACK;
               next_st.count = COUNT_RST;
            end
            else if (st.count == 8'(SETTLE_CYC + 3))
               next_st.arb = ICAP_OWN;
            else
               next_st.count = st.count + 8'h01;
         end
         ICAP_OWN:
         begin
            if (ide_done || !ide_request)
               next_st.arb = ICAP_IDLE;
         end
         ICAP_BACK:
         begin
            if (st.count == 8'(BACKOFF - 1))
            begin
               next_st.arb   = ICAP_IDLE;
               next_st.count = COUNT_RST;
            end
            else
               next_st.count = st.count + 8'h01;
         end
         default:
            next_st.arb = ICAP_IDLE;
      endcase
      if (!reset_n)
      begin
         next_st        = '0;
         next_st.arb    = ICAP_IDLE;
         next_st.tpwr   = TPWR_OFF_LEVEL;
         // Assume bus-powered straps until the real ones have settled,
         // so sharing never starts on a half-synchronised strap
         next_st.src_sync  = {3{~POWER_SELF_LEVEL}};
         next_st.rate_sync = {3{CLOCK_COMBO_LEVEL}};
      end
   end

   always_ff @(posedge clk)
      st <= next_st;

   // ===================================================
   // Outputs
   assign bus_claim_out = (st.arb == ICAP_CLAIM)
                       || (st.arb == ICAP_OWN);
   assign bus_claim_oe  = st.combo;
   assign ide_grant     = (st.arb == ICAP_OWN);
   assign ide_drive_en  = (st.arb == ICAP_OWN);
   assign combo_mode    = st.combo;
   assign fast_clock_sel = st.fast;
   assign target_power_ctrl = st.tpwr;
   assign target_power_oe   = st.inited;

   // ===================================================
   // Checks
   // A tie: our claim still pending when the peer is seen claiming
   sequence s_tie;
      st.arb == ICAP_CLAIM && st.peer && ide_request;
   endsequence

   // Both straps unchanged since the previous edge
   sequence s_straps_still;
      $stable(power_source_strap) && $stable(clock_rate_strap);
   endsequence

   a_claim_levels: assert property (!ide_request |=> !bus_claim_out)
      else $error("claim kept without a request");
   a_claim_raise: assert property (
      (st.arb == ICAP_IDLE && st.combo && !st.peer && ide_request)
      |=> bus_claim_out && !ide_drive_en)
      else $error("claim not raised for a request");
   a_idle_wait: assert property (
      (st.arb == ICAP_IDLE && st.combo && st.peer)
      |=> !bus_claim_out && !ide_drive_en)
      else $error("claim raised while peer claimed");
   a_drive_peer: assert property (
      ($rose(ide_drive_en) && st.combo) |-> $past(!st.peer))
      else $error("bus driven while peer claimed");
   a_tie_backoff: assert property (s_tie |=> !bus_claim_out [*2])
      else $error("claim kept after a tie");
   a_combo_straps: assert property (
      s_straps_still [*5] |-> combo_mode
      == (power_source_strap == POWER_SELF_LEVEL
          && clock_rate_strap == CLOCK_COMBO_LEVEL))
      else $error("combo mode wrong for straps");
   a_fast_clock: assert property (
      s_straps_still [*5] |-> fast_clock_sel
      == (power_source_strap == POWER_SELF_LEVEL || !clock_rate_strap))
      else $error("clock mode wrong for straps");
   a_power_hold: assert property (
      $rose(target_power_oe) |-> $past(init_done))
      else $error("power pin driven before init");
   a_power_keep: assert property (target_power_oe |=> target_power_oe)
      else $error("power pin released after init");
   a_power_off: assert property (
      usb_state != ICAP_USB_CONFIGURED
      |=> target_power_ctrl == TPWR_OFF_LEVEL)
      else $error("target power not cut");
   a_power_follow: assert property (
      usb_state == ICAP_USB_CONFIGURED
      |=> target_power_ctrl != TPWR_OFF_LEVEL)
      else $error("power level not from usb state");
   a_release_idle: assert property (
      (ide_grant && ide_done) |=> !ide_drive_en && !bus_claim_out)
      else $error("bus not released after done");
endmodule

// File: testbench/icap_peer.sv
// Model of the second IDE controller sharing the target bus
`timescale 1ns/1ps
// ==========
// Peer claim driver
module icap_peer
(
   input  wire logic clk,
   input  wire logic want,
   output logic      peer_claim
);
   initial peer_claim = 1'b0;
   // Changes just after an edge so the design never samples a race
   always @(posedge clk)
   begin
      peer_claim <= #1 want;
   end
endmodule

// File: testbench/testbench.sv
// Self-checking bench for the combo arbiter and power control
`timescale 1ns/1ps
// ==========
// Bench top
module testbench;
   import icap_pkg::*;
   logic      clk = 1'b0, reset_n = 1'b0;
   logic      power_strap = 1'b1, rate_strap = 1'b1;
   logic      req = 1'b0, done = 1'b0, init = 1'b0, want = 1'b0;
   icap_usb_e usb = ICAP_USB_DEFAULT;
   logic      peer, grant, drv, claim, coe, combo, fast, tpc, toe;
   int        fail_count = 0, compares = 0;
   always #10 clk = ~clk;
   icap_peer u_icap_peer (.clk(clk), .want(want), .peer_claim(peer));
   // Small back-off keeps the tie scenario short
   icap_arbiter #(.BACKOFF(2)) u_icap_arbiter (
      .clk(clk), .reset_n(reset_n), .power_source_strap(power_strap),
      // ATA target: every strap setting used here is a permitted one
      .clock_rate_strap(rate_strap), .target_type_strap_hi(1'b1),
      .target_type_strap_lo(1'b0), .peer_claim_in(peer),
      .ide_request(req), .ide_done(done), .ide_grant(grant),
      .ide_drive_en(drv), .bus_claim_out(claim), .bus_claim_oe(coe),
      .combo_mode(combo), .fast_clock_sel(fast), .init_done(init),
      .usb_state(usb), .target_power_ctrl(tpc), .target_power_oe(toe));
   task automatic chk(input logic got, input logic exp);
      compares++;
      if (got !== exp)
      begin
         fail_count++;
         $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wait_grant(input int n);
      for (int i = 0; i < n && grant !== 1'b1; i++) @(negedge clk);
      chk(grant, 1'b1);
      chk(drv, 1'b1);
      done = 1'b1;
      @(negedge clk);
      done = 1'b0;
      req = 1'b0;
      repeat (2) @(negedge clk);
      chk(claim, 1'b0);
      chk(drv, 1'b0);
   endtask
   task automatic t_plain();
      power_strap = 1'b1;
      repeat (3) @(negedge clk);
      chk(combo, 1'b0);
      chk(coe, 1'b0);
      chk(fast, 1'b0);
      req = 1'b1;
      wait_grant(4);
   endtask
   task automatic t_combo();
      power_strap = 1'b0;
      repeat (6) @(negedge clk);
      chk(combo, 1'b1);
      chk(coe, 1'b1);
      chk(fast, 1'b1);
      req = 1'b1;
      repeat (2) @(negedge clk);
      chk(claim, 1'b1);
      chk(drv, 1'b0);
      wait_grant(12);
   endtask
   task automatic t_busy();
      want = 1'b1;
      repeat (8) @(negedge clk);
      req = 1'b1;
      repeat (12) @(negedge clk) chk(drv, 1'b0);
      chk(claim, 1'b0);
      want = 1'b0;
      wait_grant(40);
   endtask
   task automatic t_tie();
      want = 1'b1;
      req = 1'b1;
      repeat (10) @(negedge clk);
      chk(claim, 1'b0);
      chk(grant, 1'b0);
      want = 1'b0;
      wait_grant(60);
   endtask
   task automatic t_power();
      usb = ICAP_USB_CONFIGURED;
      repeat (3) @(negedge clk);
      chk(toe, 1'b0);
      init = 1'b1;
      @(negedge clk);
      init = 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         usb = icap_usb_e'(i);
         repeat (2) @(negedge clk);
         chk(toe, 1'b1);
         chk(tpc, (i == 2) ? ~TPWR_OFF_LEVEL : TPWR_OFF_LEVEL);
      end
   endtask
   // Mid-run reset: outputs return to rest, straps settle again
   task automatic t_reset();
      reset_n = 1'b0;
      repeat (2) @(negedge clk);
      chk(toe, 1'b0);
      chk(tpc, TPWR_OFF_LEVEL);
      chk(claim, 1'b0);
      chk(combo, 1'b0);
      reset_n = 1'b1;
      repeat (6) @(negedge clk);
      chk(combo, 1'b1);
      chk(fast, 1'b1);
      chk(toe, 1'b0);
   endtask
   task automatic print_verdict();
      $display("Comparisons %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // ==========
   // Main sequence
   initial
   begin
      repeat (10) @(negedge clk);
      chk(claim, 1'b0);
      chk(toe, 1'b0);
      chk(tpc, TPWR_OFF_LEVEL);
      reset_n = 1'b1;
      t_plain();
      t_combo();
      t_busy();
      t_tie();
      t_power();
      t_reset();
      print_verdict();
   end
   // A hang counts as a mismatch
   initial
   begin
      #100us;
      fail_count++;
      print_verdict();
   end
endmodule
